// file: src/fbdc_ctrl.sv
// Summary of operation
// - random, random edo, random write, fast page, hyper page, late write, masked write, refresh.
// - rows and columns are 9 bits each for 256Kx16 parts with upper and lower column strobes.
// - pixel units of 8, 16 or 32 bits address the frame buffer uniformly.
// - an internal timer requests a refresh every 776 memory clock periods.
// - every refresh is a column-before-row strobe cycle.
// - one, two or four banks of 256Kx32 each are supported.
// - a 32-bit data bus and two 9-bit address buses serve up to four banks, interleaved two to one.
// - hyper page cycles run only for edo with 1 MB, or 2 and 4 MB with the 64-bit dac.
// - standard dram interleaves for 2 MB with 32-bit dac and 4 MB with 64-bit dac only.
// - page bursts to the 64-bit dac run back to back at two periods per word.
// - every strobe interval is a whole count of memory clock periods.
`timescale 1ns/1ps
`default_nettype none
module fbdc_ctrl
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration straps
   input wire fbdc_pkg::fbdc_cfg_t cfg_strap,
   // pixel access port
   input wire logic req_valid,
   input wire fbdc_pkg::fbdc_req_t req,
   output logic req_ready,
   output logic [31:0] rdata,
   output logic rvalid,
   // dram pins
   output var fbdc_pkg::fbdc_dram_t dram,
   input wire logic [31:0] md_in
);
   import fbdc_pkg::*;

   fbdc_cfg_t strap_s1;
   fbdc_cfg_t strap_s2;
   fbdc_cfg_t cfg;
   logic hyper_en;
   logic interleave;
   logic [31:0] md_s1;
   logic [31:0] md_s2;
   logic [9:0] ref_cnt;
   logic ref_pend;
   logic ref_done;
   fbdc_state_t state;
   fbdc_state_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   fbdc_req_t cur;
   logic pend;
   logic next_pend;
   logic take;
   logic page_hit;
   logic next_ready;
   logic [3:0] rd_pipe;
   fbdc_dram_t next_dram;
   logic [1:0] cur_bank;
   logic [8:0] cur_row;
   logic [8:0] cur_col;
   logic [3:0] cur_lanes;
   logic [1:0] req_bank;
   logic [8:0] req_row;
   logic [3:0] pop_mask;
   logic [23:0] req_map;

   // byte address from unit address and size, then bank, row and column split
   function automatic logic [23:0] fbdc_map(input fbdc_req_t r, input fbdc_cfg_t c,
                                            input logic il);
      logic [21:0] ba;
      logic [19:0] w;
      logic [1:0] bk;
      logic [8:0] row;
      logic [8:0] col;
      logic [3:0] ln;
      ba = r.unit_addr << r.size;
      w = ba[21:2];
      if (il)
      begin
         bk = {w[19], w[0]};
         col = w[9:1];
         row = w[18:10];
      end
      else
      begin
         bk = w[19:18];
         col = w[8:0];
         row = w[17:9];
      end
      if (c.pop == POP_1)
         bk = 2'b00;
      else if (c.pop == POP_2)
         bk[1] = 1'b0;
      case (r.size)
         PIX_8: ln = 4'h1 << ba[1:0];
         PIX_16: ln = ba[1] ? 4'hC : 4'h3;
         default: ln = 4'hF;
      endcase
      return {bk, row, col, ~ln};
   endfunction

   // straps and data pins pass two flops before use
   always_ff @(posedge clk)
   begin
      strap_s1 <= cfg_strap;
      strap_s2 <= strap_s1;
      md_s1 <= md_in;
      md_s2 <= md_s1;
   end

   // configuration follows the straps while reset is held, static afterwards
   always_ff @(posedge clk)
   begin
      if (rst)
         cfg <= strap_s2;
   end

   assign hyper_en = cfg.edo && (cfg.pop == POP_1 || cfg.dac64);
   assign interleave = cfg.edo ? (cfg.pop != POP_1 && cfg.dac64)
                     : ((cfg.pop == POP_2 && !cfg.dac64) || (cfg.pop == POP_4 && cfg.dac64));
   assign pop_mask = (cfg.pop == POP_1) ? 4'h1 : (cfg.pop == POP_2) ? 4'h3 : 4'hF;

   assign {cur_bank, cur_row, cur_col, cur_lanes} = fbdc_map(cur, cfg, interleave);
   assign req_map = fbdc_map(req, cfg, interleave);
   assign {req_bank, req_row} = req_map[23:13];
   assign take = req_valid && req_ready;
   // page stays open only for the same row and direction, and edo only when allowed
   assign page_hit = req_bank == cur_bank && req_row == cur_row && req.write == cur.write
                   && !req.wpb && (req.write || !cfg.edo || hyper_en);

   // refresh timer, needs no outside source
   always_ff @(posedge clk)
   begin
      if (rst)
         ref_cnt <= '0;
      else if (ref_cnt == REFRESH_LAST)
         ref_cnt <= '0;
      else
         ref_cnt <= ref_cnt + 10'h001;
   end

   // a new timer tick wins over the clear of the finishing refresh
   always_ff @(posedge clk)
   begin
      if (rst)
         ref_pend <= 1'b0;
      else if (ref_cnt == REFRESH_LAST)
         ref_pend <= 1'b1;
      else if (ref_done)
         ref_pend <= 1'b0;
   end

   // sequencer: each state is whole periods, half-period figures rounded up
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_pend = pend;
      ref_done = 1'b0;
      next_dram = dram;
      next_dram.md_oe_n = 1'b1;
      next_dram.we_n = 1'b1;
      case (state)
         S_IDLE:
         begin
            if (ref_pend)
            begin
               next_dram.cas_n = 4'h0;
               next_state = S_REF_CAS;
               // a request taken in the same cycle waits behind the refresh
               next_pend = pend || take;
            end
            else if (pend || take)
            begin
               next_pend = 1'b0;
               next_state = S_RAS;
            end
         end
         S_RAS:
         begin
            // column address a full period ahead of the strobe
            if (cur_bank[0])
               next_dram.ma_odd = cur_col;
            else
               next_dram.ma_even = cur_col;
            next_dram.md_out = cur.wdata;
            next_dram.md_oe_n = !cur.write;
            next_state = S_CAS;
         end
         S_CAS:
         begin
            // lanes strobe with write data and write strobe standing
            next_dram.cas_n = cur_lanes;
            next_dram.we_n = !cur.write;
            next_dram.md_oe_n = !cur.write;
            next_state = S_CP;
         end
         S_CP:
         begin
            next_dram.cas_n = ALL_CAS_HIGH;
            if (take && page_hit)
            begin
               next_state = S_CAS;
               next_pend = 1'b0;
            end
            else
            begin
               // row stays low one more period so its width is met
               if (take)
                  next_pend = 1'b1;
               next_cnt = RP_LOAD + 3'h1;
               next_state = S_PRE;
            end
         end
         S_PRE:
         begin
            next_cnt = cnt - 3'h1;
            if (cnt == RP_LOAD + 3'h1)
            begin
               next_dram.ras_n = ALL_RAS_HIGH;
               next_dram.oe_n = 1'b1;
            end
            if (cnt == 3'h0)
               next_state = S_IDLE;
         end
         S_REF_CAS:
         begin
            next_dram.ras_n = ~pop_mask;
            next_cnt = RAS_LOAD;
            next_state = S_REF_RAS;
         end
         S_REF_RAS:
         begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h0)
            begin
               ref_done = 1'b1;
               next_dram.ras_n = ALL_RAS_HIGH;
               next_dram.cas_n = ALL_CAS_HIGH;
               next_cnt = RP_LOAD;
               next_state = S_PRE;
            end
         end
         default:
            next_state = S_IDLE;
      endcase
      // row open: row on the bank's own bus, mask latched with the row strobe
      if (state == S_IDLE && next_state == S_RAS)
      begin
         next_dram.ras_n = ~(4'h1 << (pend ? cur_bank : req_bank));
         if ((pend ? cur_bank[0] : req_bank[0]))
            next_dram.ma_odd = pend ? cur_row : req_row;
         else
            next_dram.ma_even = pend ? cur_row : req_row;
         next_dram.we_n = !(pend ? cur.wpb : req.wpb);
         next_dram.md_out = pend ? cur.wpb_mask : req.wpb_mask;
         next_dram.md_oe_n = !(pend ? cur.wpb : req.wpb);
         next_dram.oe_n = pend ? cur.write : req.write;
      end
      next_ready = (next_state == S_IDLE || next_state == S_CP) && !ref_pend && !next_pend;
   end

   // page continuation re-enters the strobe through the precharge period
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= S_IDLE;
         cnt <= 3'h0;
         pend <= 1'b0;
         req_ready <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         pend <= next_pend;
         req_ready <= next_ready;
      end
   end

   // current request, loaded on every accepted handshake
   always_ff @(posedge clk)
   begin
      if (rst)
         cur <= '0;
      else if (take)
         cur <= req;
   end

   // dram pins come straight from flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dram.ras_n <= ALL_RAS_HIGH;
         dram.cas_n <= ALL_CAS_HIGH;
         dram.we_n <= 1'b1;
         dram.oe_n <= 1'b1;
         dram.ma_even <= MA_RESET;
         dram.ma_odd <= MA_RESET;
         dram.md_out <= MD_RESET;
         dram.md_oe_n <= 1'b1;
      end
      else
      begin
         dram <= next_dram;
         // a page hit loads the next column during the precharge period
         if (state == S_CP && take && page_hit)
         begin
            if (req_bank[0])
               dram.ma_odd <= req_map[12:4];
            else
               dram.ma_even <= req_map[12:4];
            dram.md_out <= req.wdata;
         end
      end
   end

   // read data returns four periods after the strobe, through the pin synchroniser
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_pipe <= 4'h0;
         rvalid <= 1'b0;
         rdata <= MD_RESET;
      end
      else
      begin
         rd_pipe <= {rd_pipe[2:0], state == S_CAS && !cur.write};
         rvalid <= rd_pipe[3];
         if (rd_pipe[3])
            rdata <= md_s2;
      end
   end

endmodule
`default_nettype wire

// file: include/fbdc_pkg.sv
package fbdc_pkg;

   // memory clock period and delays in ns, delay counts in whole periods
   localparam int MEMORY_CLOCK_PERIOD_NS = 4;
   localparam int T_RP_NS = 10;  // 2.5 periods
   localparam int RP_CYC = (T_RP_NS + MEMORY_CLOCK_PERIOD_NS - 1) / MEMORY_CLOCK_PERIOD_NS;
   localparam int T_RAS_NS = 14;  // 3.5 periods
   localparam int RAS_CYC = (T_RAS_NS + MEMORY_CLOCK_PERIOD_NS - 1) / MEMORY_CLOCK_PERIOD_NS;
   localparam logic [2:0] RP_LOAD = 3'(RP_CYC - 1);
   localparam logic [2:0] RAS_LOAD = 3'(RAS_CYC - 1);

   // refresh request interval in memory clock periods
   localparam int REFRESH_PERIODS = 776;
   localparam logic [9:0] REFRESH_LAST = 10'(REFRESH_PERIODS - 1);

   // reset values
   localparam logic [3:0] ALL_RAS_HIGH = 4'hF;
   localparam logic [3:0] ALL_CAS_HIGH = 4'hF;
   localparam logic [8:0] MA_RESET = 9'h000;
   localparam logic [31:0] MD_RESET = 32'h0000_0000;

   // pixel unit size
   typedef enum logic [1:0]
   {
      PIX_8 = 2'b00,
      PIX_16 = 2'b01,
      PIX_32 = 2'b10
   } fbdc_pix_t;

   // bank population strap
   typedef enum logic [1:0]
   {
      POP_1 = 2'b00,
      POP_2 = 2'b01,
      POP_4 = 2'b10
   } fbdc_pop_t;

   typedef enum logic [2:0]
   {
      S_IDLE = 3'b000,
      S_RAS = 3'b001,
      S_CAS = 3'b010,
      S_CP = 3'b011,
      S_PRE = 3'b100,
      S_REF_CAS = 3'b101,
      S_REF_RAS = 3'b110
   } fbdc_state_t;

   // pixel access request
   typedef struct packed
   {
      logic write;
      logic wpb;
      fbdc_pix_t size;
      logic [21:0] unit_addr;
      logic [31:0] wdata;
      logic [31:0] wpb_mask;
   } fbdc_req_t;

   // static configuration straps
   typedef struct packed
   {
      fbdc_pop_t pop;
      logic edo;
      logic dac64;
   } fbdc_cfg_t;

   // dram pin group
   typedef struct packed
   {
      logic [3:0] ras_n;
      logic [3:0] cas_n;
      logic we_n;
      logic oe_n;
      logic [8:0] ma_even;
      logic [8:0] ma_odd;
      logic [31:0] md_out;
      logic md_oe_n;
   } fbdc_dram_t;

endpackage

// file: dv/fbdc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fbdc_ctrl_properties
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched outputs
   input wire logic req_ready,
   input wire logic rvalid,
   input wire fbdc_pkg::fbdc_dram_t dram
);
   import fbdc_pkg::*;
   logic [3:0] cas_q;
   logic [10:0] gap;
   logic cbr;
   logic cas_fall;
   // column strobes ahead of row strobes mark a refresh
   assign cbr = dram.cas_n == 4'h0 && cas_q == ALL_CAS_HIGH && dram.ras_n == ALL_RAS_HIGH;
   assign cas_fall = dram.cas_n != ALL_CAS_HIGH && cas_q == ALL_CAS_HIGH;
   // previous column strobes
   always_ff @(posedge clk)
      cas_q <= dram.cas_n;
   // cycles since last refresh, saturating so it cannot wrap
   always_ff @(posedge clk)
      if (rst || cbr) gap <= 11'h000;
      else if (gap != 11'h7FF) gap <= gap + 11'h001;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   reset_idle_a: assert property ($fell(rst) |-> dram.ras_n == ALL_RAS_HIGH &&
      dram.cas_n == ALL_CAS_HIGH && dram.md_oe_n && !req_ready) else $error("pins busy after reset");
   cbr_order_a: assert property (cbr |=> dram.ras_n != ALL_RAS_HIGH && dram.cas_n == 4'h0)
      else $error("refresh row strobe late");
   ras_cas_a: assert property (cas_fall && dram.ras_n != ALL_RAS_HIGH |->
      $past(dram.ras_n, 2) == dram.ras_n) else $error("column strobe too early");
   ras_width_a: assert property (dram.ras_n != ALL_RAS_HIGH && $past(dram.ras_n) == ALL_RAS_HIGH
      |-> (dram.ras_n != ALL_RAS_HIGH) [*4]) else $error("row strobe too short");
   ras_precharge_a: assert property (dram.ras_n == ALL_RAS_HIGH &&
      $past(dram.ras_n) != ALL_RAS_HIGH |-> (dram.ras_n == ALL_RAS_HIGH) [*3]) else $error("short precharge");
   refresh_gap_a: assert property (cbr |-> gap inside {[740:800]}) else $error("refresh spacing");
   refresh_due_a: assert property (gap <= 11'd800) else $error("refresh overdue");
   rvalid_pulse_a: assert property (rvalid |=> !rvalid) else $error("rvalid too long");
   bus_fight_a: assert property (!dram.md_oe_n |-> dram.oe_n) else $error("data bus fight");
   cover property (cbr);
   cover property (rvalid ##2 rvalid);
   cover property (cas_fall && !dram.we_n);
endmodule
`default_nettype wire

// file: dv/fbdc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbdc_dram_model
(
   // clock
   input wire logic clk,
   // dram pins
   input wire fbdc_pkg::fbdc_dram_t dram,
   output logic [31:0] md_in
);
   import fbdc_pkg::*;
   logic [31:0] mem [int];
   logic [8:0] row [4];
   logic [8:0] col, ma;
   logic [3:0] cas_q, ras_q;
   logic [1:0] bk;
   logic fall;
   logic [31:0] w;
   int key;
   // open bank picks its address bus, even banks on one and odd on the other
   always_comb
   begin
      bk = 2'd0;
      for (int i = 3; i >= 0; i--)
         if (!dram.ras_n[i]) bk = 2'(i);
      ma = bk[0] ? dram.ma_odd : dram.ma_even;
      fall = dram.cas_n != 4'hF && cas_q == 4'hF && dram.ras_n != 4'hF;
      key = int'({bk, row[bk], fall ? ma : col});
   end
   initial md_in = 32'h0000_0000;
   // strobe edges; write data taken late while strobes stay low
   always @(posedge clk)
   begin
      for (int i = 0; i < 4; i++)
         if (ras_q[i] && !dram.ras_n[i]) row[i] <= i[0] ? dram.ma_odd : dram.ma_even;
      cas_q <= dram.cas_n;
      ras_q <= dram.ras_n;
      if (fall) col <= ma;
      w = mem.exists(key) ? mem[key] : 32'h0000_0000;
      if (dram.ras_n != 4'hF && !dram.we_n && !dram.md_oe_n)
      begin
         for (int l = 0; l < 4; l++)
            if (!dram.cas_n[l]) w[8*l +: 8] = dram.md_out[8*l +: 8];
         mem[key] = w;
      end
      // edo output holds while enabled; released bus toggles so stale data never matches
      if (dram.ras_n != 4'hF && !dram.oe_n && dram.cas_n != 4'hF && dram.we_n)
         md_in <= mem.exists(key) ? mem[key] : 32'h0000_0000;
      else if (dram.oe_n || dram.ras_n == 4'hF)
         md_in <= ~md_in;
   end
endmodule
`default_nettype wire

// file: dv/fbdc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fbdc_ctrl_tb;
   import fbdc_pkg::*;
   logic clk, rst, req_valid, req_ready, rvalid;
   fbdc_cfg_t cfg;
   fbdc_req_t req;
   logic [31:0] rdata, md_in;
   fbdc_dram_t dram;
   int error_cnt, compares, cyc, last_cbr;
   logic [31:0] rq[$];
   int rt[$];
   logic [3:0] lanes;
   fbdc_ctrl u_fbdc_ctrl (.clk(clk), .rst(rst), .cfg_strap(cfg), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rdata(rdata), .rvalid(rvalid), .dram(dram), .md_in(md_in));
   fbdc_dram_model u_fbdc_dram_model (.clk(clk), .dram(dram), .md_in(md_in));
   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // read data, arrival cycles, lanes struck and refresh starts
   always @(posedge clk)
   begin
      cyc++;
      lanes = lanes | ~dram.cas_n;
      if (dram.cas_n === 4'h0 && dram.ras_n === ALL_RAS_HIGH) last_cbr = cyc;
      if (rvalid === 1'b1)
      begin
         rq.push_back(rdata);
         rt.push_back(cyc);
      end
   end
   task automatic give_verdict();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hang(string what);
      error_cnt++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      give_verdict();
   endtask
   // holds the request until the edge that takes it
   task automatic send(logic w, fbdc_pix_t sz, logic [21:0] a, logic [31:0] d);
      int n;
      @(negedge clk);
      req_valid = 1'b1;
      req = '{write: w, wpb: 1'b0, size: sz, unit_addr: a, wdata: d, wpb_mask: 32'h0000_0000};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 300);
      if (req_ready !== 1'b1) hang("req_ready");
   endtask
   task automatic wait_q(int k);
      for (int n = 0; rq.size() < k; n++)
      begin
         if (n == 100) hang("rvalid");
         @(posedge clk);
      end
   endtask
   task automatic rd_chk(logic [21:0] a, logic [31:0] exp);
      rq.delete();
      send(1'b0, PIX_32, a, 32'h0000_0000);
      @(negedge clk) req_valid = 1'b0;
      wait_q(1);
      chk("rdata", exp, rq[0]);
   endtask
   task automatic t_reset();
      repeat (20) @(negedge clk);
      chk("ras_n", 32'(ALL_RAS_HIGH), 32'(dram.ras_n));
      chk("md_oe_n", 32'h1, 32'(dram.md_oe_n));
      rst = 1'b0;
      $display("test reset done");
   endtask
   task automatic t_refresh();
      int t0;
      for (int n = 0; last_cbr == 0; n++)
      begin
         if (n == 1000) hang("refresh");
         @(posedge clk);
      end
      t0 = last_cbr;
      for (int n = 0; last_cbr == t0; n++)
      begin
         if (n == 1000) hang("refresh");
         @(posedge clk);
      end
      chk("refresh interval", 32'(REFRESH_PERIODS), 32'(last_cbr - t0));
      t0 = last_cbr;
      repeat (REFRESH_PERIODS - 5) @(posedge clk);
      rd_chk(22'h000002, 32'h0000_0000);
      repeat (30) @(posedge clk);
      chk("refresh kept", 32'h1, 32'(last_cbr - t0 inside {[776:800]}));
      $display("test refresh done");
   endtask
   task automatic t_sizes();
      fbdc_pix_t sz[3] = '{PIX_8, PIX_16, PIX_32};
      logic [21:0] ad[3] = '{22'h000105, 22'h000103, 22'h000104};
      logic [3:0] ex[3] = '{4'h2, 4'hC, 4'hF};
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clk) lanes = 4'h0;
         send(1'b1, sz[i], ad[i], 32'h1234_5678);
         @(negedge clk) req_valid = 1'b0;
         repeat (8) @(posedge clk);
         chk("cas lanes", 32'(ex[i]), 32'(lanes));
      end
      $display("test sizes done");
   endtask
   task automatic t_rw();
      for (int i = 0; i < 4; i++) send(1'b1, PIX_32, 22'(i), 32'hA5C3_0000 + 32'(i));
      send(1'b1, PIX_32, 22'h03FFFF, 32'h5A5A_F00F);
      rq.delete();
      rt.delete();
      for (int i = 0; i < 4; i++) send(1'b0, PIX_32, 22'(i), 32'h0000_0000);
      send(1'b0, PIX_32, 22'h03FFFF, 32'h0000_0000);
      @(negedge clk) req_valid = 1'b0;
      wait_q(5);
      for (int i = 0; i < 4; i++) chk("burst data", 32'hA5C3_0000 + 32'(i), rq[i]);
      chk("far word", 32'h5A5A_F00F, rq[4]);
      for (int i = 0; i < 3; i++) chk("burst gap", 32'h2, 32'(rt[i + 1] - rt[i]));
      $display("test read write done");
   endtask
   task automatic t_strap();
      @(negedge clk) cfg = '{pop: POP_4, edo: 1'b1, dac64: 1'b1};
      repeat (4) @(negedge clk);
      rd_chk(22'h000001, 32'hA5C3_0001);
      $display("test strap done");
   endtask
   // main sequence
   initial
   begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      lanes = 4'h0;
      cfg = '{pop: POP_1, edo: 1'b1, dac64: 1'b1};
      t_reset();
      t_refresh();
      t_sizes();
      t_rw();
      t_strap();
      give_verdict();
   end
endmodule
bind fbdc_ctrl fbdc_ctrl_properties u_fbdc_ctrl_properties (.clk(clk), .rst(rst),
   .req_ready(req_ready), .rvalid(rvalid), .dram(dram));
`default_nettype wire
